// *** trap_regs_pkg.sv ***
// Purpose: shared constants and types for the trap summary and firmware base block
// Assumes: 64-bit processor-register data path
// Notes: register selects are internal codes
package trap_regs_pkg;

    localparam int DATA_W = 64;
    localparam int REG_IDX_W = 5;
    localparam int SEL_W = 2;

    // ************************************************************
    // register selects
    // ************************************************************
    localparam logic [SEL_W-1:0] SEL_TRAP_SUMMARY = 2'h1;
    localparam logic [SEL_W-1:0] SEL_FIRMWARE_BASE = 2'h2;

    // ************************************************************
    // trap summary field positions
    // ************************************************************
    localparam int SUM_SEXT_HI = 63;
    localparam int SUM_SEXT_LO = 48;
    localparam int SUM_REQ_HI = 47;
    localparam int SUM_REQ_LO = 42;
    localparam int SUM_EXTEND_ERR = 41;
    localparam int SUM_FETCH_LOC = 13;
    localparam int SUM_REG_HI = 12;
    localparam int SUM_REG_LO = 8;
    localparam int SUM_INT_PIPE = 7;
    localparam int SUM_FLAG_HI = 6;
    localparam int SUM_FLAG_LO = 1;
    localparam int SUM_SOFT = 0;

    // ************************************************************
    // firmware base field
    // ************************************************************
    localparam int BASE_HI = 43;
    localparam int BASE_LO = 15;
    localparam int BASE_W = BASE_HI - BASE_LO + 1;
    localparam logic [BASE_W-1:0] BASE_RESET = 29'h0000000;

    // kind of instruction that trapped
    typedef enum logic [1:0] {
        KIND_OTHER = 2'h0,
        KIND_OPERATE = 2'h1,
        KIND_LOAD = 2'h3,
        KIND_STORE = 2'h2
    } instr_kind_e;

    // six status requests, msb first: convert overflow, inexact, underflow,
    // overflow, divide by zero, invalid
    typedef struct packed {
        logic request_convert_overflow_status;
        logic request_inexact_status;
        logic request_underflow_status;
        logic request_overflow_status;
        logic request_divzero_status;
        logic request_invalid_status;
    } status_req_s;

    // six trap flags, msb first (bits 6 down to 1)
    typedef struct packed {
        logic convert_overflow_flag;
        logic rounding_loss_flag;
        logic underflow_flag;
        logic float_overflow_flag;
        logic zero_divisor_flag;
        logic bad_operation_flag;
    } trap_flags_s;

    // everything captured at trap delivery
    typedef struct packed {
        status_req_s req;
        logic return_address_extend_error;
        logic fetch_fault_location;
        instr_kind_e kind;
        logic [REG_IDX_W-1:0] rc_field;
        logic [REG_IDX_W-1:0] ra_field;
        logic int_pipe;
        trap_flags_s flags;
        logic soft_completion_flag;
    } trap_info_s;

endpackage : trap_regs_pkg

// *** firmware_base_reg.sv ***
// Purpose: firmware base address holding register
// Assumes: cleared only by chip reset
// Notes: sleep wake-up and fault reset do not touch it
`timescale 1ns/100ps
`default_nettype none
module firmware_base_reg (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // write port
    input wire logic wr_en,
    input wire logic [trap_regs_pkg::BASE_W-1:0] wr_data,
    // stored value
    output logic [trap_regs_pkg::BASE_W-1:0] base_r
);
    import trap_regs_pkg::*;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            base_r <= BASE_RESET;
        end else if (clk_en && wr_en) begin
            base_r <= wr_data;
        end
    end

endmodule : firmware_base_reg
`default_nettype wire

// *** trap_summary_and_handler_base.sv ***
// Purpose: trap summary capture and firmware base register
// Assumes: trap_deliver pulses for one cycle when a trap reaches the handler
// Assumes: trap_info is stable while trap_deliver is high
// Notes: firmware accesses via privileged register read/write strobes
// Notes: reserved bits read zero and summary writes are dropped
`timescale 1ns/100ps
`default_nettype none
module trap_summary_and_handler_base (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // trap delivery from the pipeline
    input wire logic trap_deliver,
    input wire trap_regs_pkg::trap_info_s trap_info,
    // privileged register access
    input wire logic [trap_regs_pkg::SEL_W-1:0] reg_sel,
    input wire logic privileged_register_read,
    input wire logic privileged_register_write,
    input wire logic [trap_regs_pkg::DATA_W-1:0] wr_data,
    output logic [trap_regs_pkg::DATA_W-1:0] rd_data,
    // firmware base to the fetch unit
    output logic [trap_regs_pkg::DATA_W-1:0] firmware_base
);
    import trap_regs_pkg::*;

    // ************************************************************
    // select decoding
    // ************************************************************
    // compares one register select against one register code
    function automatic logic sel_match(
        input logic [SEL_W-1:0] sel,
        input logic [SEL_W-1:0] code
    );
        return sel == code;
    endfunction : sel_match

    // ************************************************************
    // captured summary fields
    // ************************************************************
    status_req_s req_r;
    logic extend_err_r;
    logic fetch_loc_r;
    logic [REG_IDX_W-1:0] reg_idx_r;
    logic int_pipe_r;
    trap_flags_s flags_r;
    logic soft_r;
    logic [REG_IDX_W-1:0] reg_idx_nxt;

    // ************************************************************
    // summary and read path wires
    // ************************************************************
    wire logic [SUM_SEXT_HI-SUM_SEXT_LO:0] sext_field;
    logic [SUM_REQ_HI-SUM_REQ_LO:0] req_field;
    logic [SUM_REG_HI-SUM_REG_LO:0] reg_field;
    logic [SUM_FLAG_HI-SUM_FLAG_LO:0] flag_field;
    logic [DATA_W-1:0] summary_word;
    logic [DATA_W-1:0] sum_read;
    logic [DATA_W-1:0] base_read;
    logic [DATA_W-1:0] rd_nxt;

    // ************************************************************
    // firmware base path wires
    // ************************************************************
    logic [BASE_W-1:0] base_val;
    logic [BASE_W-1:0] base_wr_field;
    logic [DATA_W-1:0] base_word;
    logic base_wr;

    // ************************************************************
    // access qualifiers
    // ************************************************************
    logic take_trap;
    logic take_read;
    logic take_write;
    logic sel_summary;
    logic sel_base;

    // clk_en low freezes every register, so each strobe is gated here
    assign take_trap = clk_en && trap_deliver;
    assign take_read = clk_en && privileged_register_read;
    assign take_write = clk_en && privileged_register_write;
    assign sel_summary = sel_match(reg_sel, SEL_TRAP_SUMMARY);
    assign sel_base = sel_match(reg_sel, SEL_FIRMWARE_BASE);

    // ************************************************************
    // register index selection
    // ************************************************************
    // operate uses result field; load and store use first operand field
    assign reg_idx_nxt = (trap_info.kind == KIND_OPERATE) ? trap_info.rc_field
                                                          : trap_info.ra_field;

    // ************************************************************
    // trap capture, one short process per field group
    // ************************************************************
    // float control status requests
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            req_r <= '0;
        end else if (take_trap) begin
            req_r <= trap_info.req;
        end
    end

    // fetch fault reporting
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            extend_err_r <= 1'b0;
            fetch_loc_r <= 1'b0;
        end else if (take_trap) begin
            extend_err_r <= trap_info.return_address_extend_error;
            fetch_loc_r <= trap_info.fetch_fault_location;
        end
    end

    // register index, undefined outside load, store and operate traps
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_idx_r <= '0;
        end else if (take_trap) begin
            reg_idx_r <= reg_idx_nxt;
        end
    end

    // arithmetic trap flags and software completion
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            int_pipe_r <= 1'b0;
            flags_r <= '0;
            soft_r <= 1'b0;
        end else if (take_trap) begin
            int_pipe_r <= trap_info.int_pipe;
            flags_r <= trap_info.flags;
            soft_r <= trap_info.soft_completion_flag;
        end
    end

    // ************************************************************
    // summary word assembly, reserved bits zero
    // ************************************************************
    // upper bits repeat the convert overflow request
    generate
        for (genvar sx = 0; sx < SUM_SEXT_HI - SUM_SEXT_LO + 1; sx = sx + 1) begin : g_sext
            assign sext_field[sx] = req_r.request_convert_overflow_status;
        end
    endgenerate

    assign req_field = req_r;
    assign reg_field = reg_idx_r;
    assign flag_field = flags_r;

    always_comb begin
        summary_word = '0;
        summary_word[SUM_SEXT_HI:SUM_SEXT_LO] = sext_field;
        summary_word[SUM_REQ_HI:SUM_REQ_LO] = req_field;
        summary_word[SUM_EXTEND_ERR] = extend_err_r;
        summary_word[SUM_FETCH_LOC] = fetch_loc_r;
        summary_word[SUM_REG_HI:SUM_REG_LO] = reg_field;
        summary_word[SUM_INT_PIPE] = int_pipe_r;
        summary_word[SUM_FLAG_HI:SUM_FLAG_LO] = flag_field;
        summary_word[SUM_SOFT] = soft_r;
    end

    // ************************************************************
    // firmware base register
    // ************************************************************
    // own module so that only chip reset clears the base
    assign base_wr_field = wr_data[BASE_HI:BASE_LO];
    assign base_wr = take_write && sel_base;

    firmware_base_reg firmware_base_reg_i (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .wr_en(base_wr),
        .wr_data(base_wr_field),
        .base_r(base_val)
    );

    always_comb begin
        base_word = '0;
        base_word[BASE_HI:BASE_LO] = base_val;
    end

    // ************************************************************
    // firmware base output to the fetch unit
    // ************************************************************
    assign firmware_base = base_word;

    // ************************************************************
    // read port, summary writes ignored
    // ************************************************************
    // unmapped selects leave both terms zero
    assign sum_read = sel_summary ? summary_word : '0;
    assign base_read = sel_base ? base_word : '0;
    assign rd_nxt = sum_read | base_read;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (take_read) begin
            rd_data <= rd_nxt;
        end
    end

endmodule : trap_summary_and_handler_base
`default_nettype wire

// *** trap_regs_monitor.sv ***
// Purpose: port checker for the trap summary and firmware base block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the top module
`timescale 1ns/100ps
`default_nettype none
module trap_regs_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // trap capture and register access
    input wire logic trap_deliver,
    input wire trap_regs_pkg::trap_info_s trap_info,
    input wire logic [trap_regs_pkg::SEL_W-1:0] reg_sel,
    input wire logic privileged_register_read,
    input wire logic privileged_register_write,
    input wire logic [trap_regs_pkg::DATA_W-1:0] wr_data,
    input wire logic [trap_regs_pkg::DATA_W-1:0] rd_data,
    input wire logic [trap_regs_pkg::DATA_W-1:0] firmware_base
);
    import trap_regs_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    trap_info_s cap_r;
    wire logic rd_t = privileged_register_read && clk_en;
    wire logic rd_s = rd_t && reg_sel == SEL_TRAP_SUMMARY;
    wire logic wr_b = privileged_register_write && clk_en && reg_sel == SEL_FIRMWARE_BASE;
    wire logic [4:0] idx_exp = cap_r.kind == KIND_OPERATE ? cap_r.rc_field : cap_r.ra_field;
    always_ff @(posedge core_clk) if (trap_deliver && clk_en) cap_r <= trap_info;
    // ****************************************
    // assertions
    // ****************************************
    AST_BASE_WR: assert property (wr_b |=> firmware_base[43:15] == $past(wr_data[43:15]))
        else $error("base write lost");
    AST_BASE_RSV: assert property (firmware_base[63:44] == 20'h0 && firmware_base[14:0] == 15'h0)
        else $error("base reserved bits set");
    AST_BASE_HOLD: assert property (!wr_b |=> $stable(firmware_base))
        else $error("base changed without write");
    AST_RD_ZERO: assert property (rd_t && reg_sel != SEL_TRAP_SUMMARY && reg_sel != SEL_FIRMWARE_BASE |=> rd_data == 64'h0)
        else $error("unmapped read not zero");
    AST_RD_BASE: assert property (rd_t && reg_sel == SEL_FIRMWARE_BASE |=> rd_data == $past(firmware_base))
        else $error("base read mismatch");
    AST_RD_HOLD: assert property (!rd_t |=> $stable(rd_data))
        else $error("read data changed without a taken read");
    AST_SEXT: assert property (rd_s |=> rd_data[63:48] == {16{rd_data[47]}} && rd_data[40:14] == 27'h0)
        else $error("summary upper bits wrong");
    AST_CAPTURE: assert property ((trap_deliver && clk_en) ##[1:3] (rd_s && !trap_deliver) |=>
        rd_data[47:41] == {cap_r.req, cap_r.return_address_extend_error} && rd_data[13] == cap_r.fetch_fault_location
        && rd_data[7:0] == {cap_r.int_pipe, cap_r.flags, cap_r.soft_completion_flag})
        else $error("summary capture mismatch");
    AST_REG_IDX: assert property ((trap_deliver && clk_en) ##[1:3] (rd_s && !trap_deliver && cap_r.kind != KIND_OTHER) |=>
        rd_data[12:8] == idx_exp)
        else $error("register index mismatch");
    cover property (wr_b);
    cover property (trap_deliver && !clk_en);
    cover property ((trap_deliver && clk_en) ##[1:3] rd_s);
endmodule : trap_regs_monitor
bind trap_summary_and_handler_base trap_regs_monitor trap_regs_monitor_i (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(clk_en), .trap_deliver(trap_deliver), .trap_info(trap_info), .reg_sel(reg_sel),
    .privileged_register_read(privileged_register_read), .privileged_register_write(privileged_register_write),
    .wr_data(wr_data), .rd_data(rd_data), .firmware_base(firmware_base));
`default_nettype wire

// *** testbench.sv ***
// Purpose: self-checking bench for the trap summary block
// Assumes: reads answer on the taken edge, checked at the next negedge
// Notes: driver queues expected reads, monitor compares
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import trap_regs_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n, clk_en, trap_deliver, got;
    logic privileged_register_read, privileged_register_write;
    trap_info_s trap_info, ti;
    logic [1:0] reg_sel;
    logic [63:0] wr_data, rd_data, firmware_base, sum, base, w;
    logic [31:0] seed, r;
    logic [63:0] q[$];
    int n_errors, n_tests;
    trap_summary_and_handler_base trap_summary_and_handler_base_i (.core_clk(core_clk), .rst_n(rst_n),
        .clk_en(clk_en), .trap_deliver(trap_deliver), .trap_info(trap_info), .reg_sel(reg_sel),
        .privileged_register_read(privileged_register_read), .privileged_register_write(privileged_register_write),
        .wr_data(wr_data), .rd_data(rd_data), .firmware_base(firmware_base));
    always #5 core_clk = ~core_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [63:0] sum_of(trap_info_s t);
        logic [4:0] ix;
        ix = t.kind == KIND_OPERATE ? t.rc_field : t.ra_field;
        return {{16{t.req[5]}}, t.req, t.return_address_extend_error, 27'h0, t.fetch_fault_location, ix,
            t.int_pipe, t.flags, t.soft_completion_flag};
    endfunction : sum_of
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t read %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic op(input logic c, d, rd, wr, input logic [1:0] s, input logic [63:0] wd);
        @(negedge core_clk);
        trap_info = ti;
        {clk_en, trap_deliver, privileged_register_read, privileged_register_write, reg_sel, wr_data} =
            {c, d, rd, wr, s, wd};
    endtask : op
    task automatic rdx(input logic [1:0] s, input logic [63:0] e);
        q.push_back(e);
        op(1'b1, 1'b0, 1'b1, 1'b0, s, 64'h0);
    endtask : rdx
    task automatic end_of_test();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // ****************************************
    // monitor and stimulus
    // ****************************************
    always @(posedge core_clk) got <= privileged_register_read && clk_en && rst_n;
    always @(negedge core_clk) if (got === 1'b1) chk(rd_data, q.pop_front());
    initial begin
        // about 190 cycles of work, over ten times that as margin
        repeat (2200) @(posedge core_clk);
        n_errors++;
        end_of_test();
    end
    initial begin
        {rst_n, trap_deliver, privileged_register_read, privileged_register_write} = '0;
        {clk_en, reg_sel, wr_data, sum} = '0;
        ti = '0;
        trap_info = '0;
        n_errors = 0;
        n_tests = 0;
        seed = 32'h31F9319D;
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        rdx(SEL_FIRMWARE_BASE, 64'h0);
        rdx(SEL_TRAP_SUMMARY, 64'h0);
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            ti = r[27:0];
            if (ti.kind == KIND_OTHER) ti.kind = KIND_STORE;
            if (r[31] || i < 4) sum = sum_of(ti);
            op(r[31] || i < 4, 1'b1, 1'b0, 1'b0, 2'h0, 64'h0);
            w = {rnd(), rnd()};
            op(1'b1, 1'b0, 1'b0, 1'b1, SEL_TRAP_SUMMARY, w);
            rdx(SEL_TRAP_SUMMARY, sum);
            op(1'b1, 1'b0, 1'b0, 1'b1, SEL_FIRMWARE_BASE, w);
            op(1'b0, 1'b0, 1'b1, 1'b1, SEL_FIRMWARE_BASE, ~w);
            base = w & 64'h00000FFFFFFF8000;
            rdx(SEL_FIRMWARE_BASE, base);
            chk(firmware_base, base);
            rdx(i[0] ? 2'h0 : 2'h3, 64'h0);
        end
        op(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 64'h0);
        rst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        rdx(SEL_FIRMWARE_BASE, 64'h0);
        rdx(SEL_TRAP_SUMMARY, 64'h0);
        op(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 64'h0);
        repeat (2) @(negedge core_clk);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
